// [rtl/asrc_pkg.sv]
// constants, state codes and decode helpers for the sleep rail controller
package asrc_pkg;

  // clock and timing
  localparam int ASRC_CLK_KHZ = 10_000;
  localparam real ASRC_POR_EXT_MS = 3.3;
  localparam real ASRC_DEGLITCH_US = 200.0;
  localparam real ASRC_MAIN_WAIT_MS = 50.0;
  localparam int ASRC_POR_CYC = int'($ceil(ASRC_POR_EXT_MS * ASRC_CLK_KHZ));
  localparam int ASRC_DEGLITCH_CYC = int'($ceil(ASRC_DEGLITCH_US * ASRC_CLK_KHZ / 1000.0));
  localparam int ASRC_MAIN_WAIT_CYC = int'($ceil(ASRC_MAIN_WAIT_MS * ASRC_CLK_KHZ));
  localparam int ASRC_TMR_W = 20;

  // register map, byte addresses
  localparam logic [7:0] ASRC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ASRC_STATUS_OFS = 8'h04;
  localparam logic [31:0] ASRC_CTRL_RST = 32'h0000_0000;
  localparam int ASRC_CTRL_SHDN_BIT = 0;

  // status field positions
  localparam int ASRC_ST_STATE_LSB = 0;
  localparam int ASRC_ST_POR_BIT = 2;
  localparam int ASRC_ST_MAIN_BIT = 3;
  localparam int ASRC_ST_MEM33_BIT = 4;
  localparam int ASRC_ST_AUXKEEP_BIT = 5;
  localparam int ASRC_ST_D5KEEP_BIT = 6;
  localparam int ASRC_ST_FAULT_BIT = 7;
  localparam int ASRC_ST_SHDN_BIT = 8;
  localparam int ASRC_ST_DGL_BIT = 9;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SUSPEND = 2'b10,
    ST_SOFTOFF = 2'b11
  } asrc_state_e;

  // ST_RESET here marks the forbidden combination
  function automatic asrc_state_e asrc_decode(input logic susp_n, input logic off_n);
    asrc_decode = ST_RESET;
    if (susp_n && off_n) asrc_decode = ST_ACTIVE;
    else if (!susp_n && off_n) asrc_decode = ST_SUSPEND;
    else if (!susp_n && !off_n) asrc_decode = ST_SOFTOFF;
  endfunction : asrc_decode

  function automatic logic asrc_legal(input asrc_state_e from, input asrc_state_e to);
    asrc_legal = (to != ST_RESET) && (from != to) &&
                 ((from == ST_ACTIVE) || (to == ST_ACTIVE) || (from == ST_RESET));
  endfunction : asrc_legal

endpackage : asrc_pkg

// [rtl/asrc_timer.sv]
// one-shot down counter with a single-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module asrc_timer #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] load,
  // status
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt;

  // start wins over abort so a restart never gets lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= load;
      end else if (abort) begin
        cnt <= '0;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
        if (cnt == W'(1)) done <= 1'b1;
      end
    end
  end

  assign busy = (cnt != '0);

endmodule : asrc_timer
`default_nettype wire

// [rtl/asrc_core.sv]
// sleep-state decode, rail enables and fault flag for the triple rail controller
//
// Notes on behaviour
// RULE1: after standby supply is good, hold internal reset 3.3 ms more
// RULE2: capture memory voltage select once per standby power-on trip
// RULE3: both high active, off high suspend low RAM, both low off
// RULE4: aux 3.3 V on except soft-off with keep enable high
// RULE5: 5 V dual on in active, in sleep only if keep enable set
// RULE6: memory rail on in active and suspend, off in soft-off
// RULE7: captured select picks 2.5 V (low R) or 3.3 V (high R)
// RULE8: no direct move between suspend and soft-off
// RULE9: keep enables follow pins only in active, reset or shutdown
// RULE10: suspend request change starts 200 us timer, then valid request applies
// RULE11: soft-start node low turns all outputs off and fault low; mem_level_33 still follows the captured select
// RULE12: active state drives main switch gate
// RULE13: sleep drives aux 3.3 V regulator and 5 V sleep switch
// RULE14: memory uses internal pass in sleep, external drive in active
// RULE15: under-voltage watched on memory, aux and 5 V rails
// RULE16: keep enables latched on sleep entry, reset release, shutdown exit
// RULE17: fault high when a rail below 69 percent, no shutdown
// RULE18: no under-voltage detect on disabled rails or during ramp
// RULE19: powered into active, switches wait 50 ms after 12 V good
// RULE20: inputs synchronised, timeouts counted in clock cycles; only the request and keep enable pins are synchronised
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module asrc_core
  import asrc_pkg::*;
#(
  parameter int POR_CYC = ASRC_POR_CYC,
  parameter int MAIN_WAIT_CYC = ASRC_MAIN_WAIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // chipset requests and keep enables
  input wire logic suspend_ram_req_n,
  input wire logic soft_off_req_n,
  input wire logic aux33_keep_en_n,
  input wire logic dual5_keep_en,
  // supply and soft-start status
  input wire logic standby_supply,
  input wire logic supply12_ok,
  input wire logic soft_start_low,
  input wire logic soft_start_done,
  input wire logic mem_select_resistor,
  // rail under-voltage comparators, high when below threshold
  input wire logic mem_rail_sense,
  input wire logic aux33_rail_sense,
  input wire logic dual5_rail_sense,
  // drive outputs
  output logic main_switch_gate,
  output logic aux33_sleep_drive,
  output logic dual5_sleep_gate,
  output logic mem_active_drive,
  output logic mem_active_full_on,
  output logic mem_sleep_pass,
  output logic mem_level_33,
  output logic fault_memsel
);

  localparam logic [ASRC_TMR_W-1:0] POR_LOAD = ASRC_TMR_W'(POR_CYC);
  localparam logic [ASRC_TMR_W-1:0] MAIN_LOAD = ASRC_TMR_W'(MAIN_WAIT_CYC);
  localparam logic [ASRC_TMR_W-1:0] DGL_LOAD = ASRC_TMR_W'(ASRC_DEGLITCH_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic susp_n;
  logic off_n;
  logic aux_keep_pin_n;
  logic d5_keep_pin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'hc; // requests idle high, so no false edge after reset
      pin_sync <= 4'hc;
    end else begin
      pin_meta <= {suspend_ram_req_n, soft_off_req_n, aux33_keep_en_n, dual5_keep_en}; // RULE20
      pin_sync <= pin_meta;
    end
  end

  assign {susp_n, off_n, aux_keep_pin_n, d5_keep_pin} = pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // standby power-on extension and memory select capture

  logic standby_q;
  logic por_done;
  logic por_tmr_done;
  logic por_busy;
  logic mem_sel33;
  logic [31:0] ctrl;
  logic shutdown;

  assign shutdown = soft_start_low | ctrl[ASRC_CTRL_SHDN_BIT];

  asrc_timer #(.W(ASRC_TMR_W)) u_por_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(standby_supply & ~standby_q),
    .abort(~standby_supply),
    .load(POR_LOAD),
    .busy(por_busy),
    .done(por_tmr_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_q <= 1'b0;
      por_done <= 1'b0;
      mem_sel33 <= 1'b0;
    end else begin
      standby_q <= standby_supply;
      if (!standby_supply) begin
        por_done <= 1'b0; // RULE1
      end else if (por_tmr_done) begin
        por_done <= 1'b1; // RULE1
        mem_sel33 <= mem_select_resistor; // RULE2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 12 V settle wait before the main switches close

  logic main_ready;
  logic main_busy;
  logic main_tmr_done;
  logic main_start;

  assign main_start = supply12_ok & por_done & ~main_ready & ~main_busy & ~main_tmr_done;

  asrc_timer #(.W(ASRC_TMR_W)) u_main_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(main_start),
    .abort(~supply12_ok | ~por_done),
    .load(MAIN_LOAD),
    .busy(main_busy),
    .done(main_tmr_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ready <= 1'b0;
    end else if (!supply12_ok || !por_done) begin
      main_ready <= 1'b0;
    end else if (main_tmr_done) begin
      main_ready <= 1'b1; // RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request deglitch and state machine

  asrc_state_e state;
  asrc_state_e next_state;
  asrc_state_e req_state;
  logic susp_q;
  logic dgl_busy;
  logic dgl_done;

  assign req_state = asrc_decode(susp_n, off_n); // RULE3

  // only the suspend request restarts the filter; it may lead soft-off by 200 us
  asrc_timer #(.W(ASRC_TMR_W)) u_dgl_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(por_done & (susp_n ^ susp_q)), // RULE10
    .abort(~por_done),
    .load(DGL_LOAD),
    .busy(dgl_busy),
    .done(dgl_done)
  );

  always_comb begin
    next_state = state;
    if (!por_done) begin
      next_state = ST_RESET; // RULE1
    end else if (state == ST_RESET) begin
      if (req_state != ST_RESET) next_state = req_state;
    end else if (dgl_done && asrc_legal(state, req_state)) begin
      next_state = req_state; // RULE8 RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RESET;
      susp_q <= 1'b1;
    end else begin
      state <= next_state;
      susp_q <= susp_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // keep enable latches, transparent outside sleep

  logic aux_keep_n;
  logic d5_keep;
  logic keep_open;

  assign keep_open = (state == ST_ACTIVE) || (state == ST_RESET) || shutdown; // RULE9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_keep_n <= 1'b0;
      d5_keep <= 1'b0;
    end else if (keep_open) begin
      aux_keep_n <= aux_keep_pin_n; // RULE16
      d5_keep <= d5_keep_pin; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail enables, drive outputs and fault

  logic is_active;
  logic is_sleep;
  logic aux_on;
  logic d5_on;
  logic mem_on;
  logic uv_any;

  assign is_active = (state == ST_ACTIVE) && !shutdown;
  assign is_sleep = ((state == ST_SUSPEND) || (state == ST_SOFTOFF)) && !shutdown; // RULE11
  assign aux_on = is_active || (state == ST_SUSPEND && is_sleep) ||
                  (state == ST_SOFTOFF && is_sleep && !aux_keep_n); // RULE4
  assign d5_on = is_active || (is_sleep && d5_keep); // RULE5
  assign mem_on = is_active || (state == ST_SUSPEND && is_sleep); // RULE6
  // a rail whose switches are still open counts as disabled
  assign uv_any = soft_start_done && // RULE18
                  ((mem_rail_sense && mem_on && (is_sleep || main_ready)) ||
                   (aux33_rail_sense && aux_on && (is_sleep || main_ready)) ||
                   (dual5_rail_sense && d5_on && (is_sleep || main_ready))); // RULE15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_switch_gate <= 1'b0;
      mem_active_drive <= 1'b0;
      mem_active_full_on <= 1'b0;
    end else begin
      main_switch_gate <= is_active && main_ready; // RULE12 RULE19
      mem_active_drive <= is_active && main_ready; // RULE14
      mem_active_full_on <= is_active && main_ready && mem_sel33; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux33_sleep_drive <= 1'b0;
      dual5_sleep_gate <= 1'b0;
      mem_sleep_pass <= 1'b0;
    end else begin
      aux33_sleep_drive <= is_sleep && aux_on; // RULE13
      dual5_sleep_gate <= is_sleep && d5_on; // RULE13
      mem_sleep_pass <= is_sleep && mem_on; // RULE14
    end
  end

  // flag only: nothing is switched off by a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_memsel <= 1'b0;
      mem_level_33 <= 1'b0;
    end else begin
      fault_memsel <= uv_any && !shutdown; // RULE17 RULE11
      mem_level_33 <= mem_sel33; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file, zero wait states

  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic [31:0] status;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_ctrl = (paddr == ASRC_CTRL_OFS);
  assign hit_status = (paddr == ASRC_STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = access && !hit_ctrl && !hit_status;

  always_comb begin
    status = 32'h0000_0000;
    status[ASRC_ST_STATE_LSB +: 2] = state;
    status[ASRC_ST_POR_BIT] = por_done;
    status[ASRC_ST_MAIN_BIT] = main_ready;
    status[ASRC_ST_MEM33_BIT] = mem_sel33;
    status[ASRC_ST_AUXKEEP_BIT] = aux_keep_n;
    status[ASRC_ST_D5KEEP_BIT] = d5_keep;
    status[ASRC_ST_FAULT_BIT] = fault_memsel;
    status[ASRC_ST_SHDN_BIT] = shutdown;
    status[ASRC_ST_DGL_BIT] = dgl_busy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ASRC_CTRL_RST;
    end else if (access && pwrite && hit_ctrl) begin
      ctrl <= pwdata & 32'h0000_0001;
    end
  end

  // read data is sampled in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= hit_ctrl ? ctrl : (hit_status ? status : 32'h0000_0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_POR_HOLD: assert property ( // RULE1
    !standby_supply |=> !por_done ##1 (state == ST_RESET))
    else $error("state left reset while standby supply low");

  AST_MEMSEL_FIXED: assert property ( // RULE2
    !por_tmr_done |=> $stable(mem_sel33))
    else $error("memory select changed outside a power-on capture");

  AST_NO_SLEEP_SWAP: assert property ( // RULE8
    (state == ST_SUSPEND) |=> (state != ST_SOFTOFF))
    else $error("direct move from suspend to soft-off");

  AST_NO_OFF_SWAP: assert property ( // RULE8
    (state == ST_SOFTOFF) |=> (state != ST_SUSPEND))
    else $error("direct move from soft-off to suspend");

  AST_SLEEP_KEEP: assert property ( // RULE9
    ((state == ST_SUSPEND) || (state == ST_SOFTOFF)) && !shutdown |=> $stable(d5_keep))
    else $error("keep enable changed during sleep");

  AST_MOVE_AFTER_FILTER: assert property ( // RULE10
    (state != ST_RESET) && (next_state != state) && por_done |-> dgl_done)
    else $error("state moved without the deglitch timeout");

  AST_SHUTDOWN_OFF: assert property ( // RULE11
    shutdown |=> !main_switch_gate && !aux33_sleep_drive && !dual5_sleep_gate &&
                 !mem_sleep_pass && !mem_active_drive && !fault_memsel)
    else $error("output active during shutdown");

  AST_MAIN_GATE: assert property ( // RULE12
    (state == ST_ACTIVE) && main_ready && !shutdown |=> main_switch_gate)
    else $error("main switch gate low in ready active state");

  AST_SOFTOFF_MEM: assert property ( // RULE6
    (state == ST_SOFTOFF) |=> !mem_sleep_pass && !mem_active_drive)
    else $error("memory rail driven in soft-off");

  AST_MAIN_WAIT: assert property ( // RULE19
    $rose(main_ready) |-> $past(main_tmr_done) && supply12_ok)
    else $error("main switches released without the 12 V wait");

  AST_FAULT_BLANK: assert property ( // RULE18
    !soft_start_done |=> !fault_memsel)
    else $error("fault flagged during soft-start ramp");

  COV_SUSPEND: cover property (
    (state == ST_ACTIVE) ##1 (state == ST_SUSPEND));
  COV_SOFTOFF_WAKE: cover property (
    (state == ST_SOFTOFF) ##1 (state == ST_ACTIVE));
  COV_FAULT: cover property ($rose(fault_memsel));
  COV_MAIN_READY: cover property ($rose(main_ready) && (state == ST_ACTIVE));

endmodule : asrc_core
`default_nettype wire

// [tb/asrc_chipset_model.sv]
// chipset model that drives the two sleep request pins
`timescale 1ns/1ns
`default_nettype none
module asrc_chipset_model
  import asrc_pkg::*;
#(
  parameter int SKEW = 100
) (
  // clock
  input wire logic pclk,
  // bench commands, ST_RESET asks for the forbidden pair
  input wire logic [1:0] target,
  input wire logic glitch,
  // request pins
  output logic suspend_ram_req_n,
  output logic soft_off_req_n
);
  int cnt = 0;
  logic susp_q = 1'b1;
  logic off_q = 1'b1;

  always @(posedge pclk) begin
    susp_q <= !(target inside {ST_SUSPEND, ST_SOFTOFF});
    if (susp_q) begin
      cnt <= 0;
    end else if (cnt < SKEW) begin
      cnt <= cnt + 1;
    end
    // soft-off trails suspend but stays well inside the deglitch window
    off_q <= !((target == ST_SOFTOFF && cnt >= SKEW) || target == ST_RESET);
  end

  // glitch lets the bench disturb the suspend pin on purpose
  assign suspend_ram_req_n = susp_q ^ glitch;
  assign soft_off_req_n = off_q;
endmodule : asrc_chipset_model
`default_nettype wire

// [tb/asrc_core_tb.sv]
// self-checking bench for the sleep rail controller core
`timescale 1ns/1ns
`default_nettype none
module asrc_core_tb
  import asrc_pkg::*;
();
  localparam int POR = 20;
  localparam int MW = 30;
  localparam int DG = 2100;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, susp_n, off_n, glitch = 1'b0;
  logic aux_n = 1'b0, d5 = 1'b1, sb = 1'b0, s12 = 1'b0, ss_low = 1'b0, ss_done = 1'b0;
  logic msel = 1'b1, mem_s = 1'b0, aux_s = 1'b0, d5_s = 1'b0;
  logic sw, auxd, d5g, drv, full, pass, lvl, flt;
  asrc_state_e target = ST_ACTIVE;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] outs;
  assign outs = {sw, auxd, d5g, drv, full, pass, lvl, flt};

  asrc_core #(.POR_CYC(POR), .MAIN_WAIT_CYC(MW)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .suspend_ram_req_n(susp_n), .soft_off_req_n(off_n), .aux33_keep_en_n(aux_n),
    .dual5_keep_en(d5), .standby_supply(sb), .supply12_ok(s12), .soft_start_low(ss_low),
    .soft_start_done(ss_done), .mem_select_resistor(msel), .mem_rail_sense(mem_s),
    .aux33_rail_sense(aux_s), .dual5_rail_sense(d5_s), .main_switch_gate(sw),
    .aux33_sleep_drive(auxd), .dual5_sleep_gate(d5g), .mem_active_drive(drv),
    .mem_active_full_on(full), .mem_sleep_pass(pass), .mem_level_33(lvl),
    .fault_memsel(flt)
  );

  asrc_chipset_model #(.SKEW(100)) i_chipset (
    .pclk(pclk), .target(target), .glitch(glitch),
    .suspend_ram_req_n(susp_n), .soft_off_req_n(off_n)
  );

  initial begin
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      $display("MISMATCH t=%0t bus answer missing", $time);
      stop_test();
    end
  endtask : apb

  // keep bits, power-on flag and state in one compare
  task automatic status(input logic [4:0] exp, input string what);
    apb(1'b0, ASRC_STATUS_OFS, 32'h0000_0000);
    check({rd[6:5], rd[2:0]}, exp, what);
  endtask : status

  // short disturbance on suspend restarts the deglitch timer
  task automatic pulse();
    glitch <= 1'b1;
    repeat (5) @(posedge pclk);
    glitch <= 1'b0;
    repeat (DG) @(posedge pclk);
  endtask : pulse

  initial begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    $display("MISMATCH t=%0t run too long", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] exp;
    logic a;
    logic k;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(outs, 8'h00, "outputs after reset");
    check(pready, 1'b1, "pready");
    repeat (4) @(posedge pclk);
    status(5'b10000, "keeps follow pins in reset");
    sb <= 1'b1;
    repeat (POR - 5) @(posedge pclk);
    status(5'b10000, "power-on delay running");
    repeat (10) @(posedge pclk);
    status(5'b10101, "active after power-on");
    msel <= 1'b0;
    check(sw, 1'b0, "switches wait for 12 V");
    s12 <= 1'b1;
    repeat (MW - 10) @(posedge pclk);
    check(sw, 1'b0, "switches during 12 V wait");
    repeat (20) @(posedge pclk);
    check(outs, 8'h9a, "active at 3.3 V");
    $display("test power-on done");
    for (int i = 0; i < 8; i++) begin
      a = i[1];
      k = i[2];
      aux_n <= a;
      d5 <= k;
      repeat (5) @(posedge pclk);
      target <= i[0] ? ST_SOFTOFF : ST_SUSPEND;
      repeat (DG) @(posedge pclk);
      exp = {2'b00, k, 2'b00, !i[0], 2'b10};
      exp[6] = i[0] ? !a : 1'b1;
      check(outs, exp, "sleep outputs");
      status({k, a, 1'b1, i[0] ? 2'b11 : 2'b10}, "sleep state");
      aux_n <= !a;
      d5 <= !k;
      repeat (10) @(posedge pclk);
      check(outs, exp, "keep change in sleep ignored");
      target <= ST_ACTIVE;
      repeat (DG) @(posedge pclk);
      check(outs, 8'h9a, "back to active");
    end
    $display("test sleep states done");
    target <= ST_SUSPEND;
    repeat (DG) @(posedge pclk);
    target <= ST_SOFTOFF;
    repeat (200) @(posedge pclk);
    pulse();
    status({d5, aux_n, 3'b110}, "suspend to soft-off refused");
    target <= ST_ACTIVE;
    repeat (DG) @(posedge pclk);
    target <= ST_RESET;
    repeat (10) @(posedge pclk);
    pulse();
    status({d5, aux_n, 3'b101}, "forbidden pair keeps state");
    target <= ST_ACTIVE;
    $display("test refusals done");
    ss_done <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      {mem_s, aux_s, d5_s} <= 3'b100 >> r;
      repeat (4) @(posedge pclk);
      check(outs, 8'h9b, "rail under-voltage flagged");
      {mem_s, aux_s, d5_s} <= 3'b000;
      repeat (4) @(posedge pclk);
      check(flt, 1'b0, "fault not sticky");
    end
    ss_done <= 1'b0;
    mem_s <= 1'b1;
    repeat (4) @(posedge pclk);
    check(flt, 1'b0, "fault blanked during ramp");
    ss_done <= 1'b1;
    ss_low <= 1'b1;
    repeat (4) @(posedge pclk);
    check({outs[7:2], outs[0]}, 7'h00, "soft-start low forces off");
    ss_low <= 1'b0;
    mem_s <= 1'b0;
    $display("test fault done");
    apb(1'b1, ASRC_CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    check({outs[7:2], outs[0]}, 7'h00, "software shutdown");
    apb(1'b0, ASRC_CTRL_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0001, "control readback");
    apb(1'b1, ASRC_CTRL_OFS, 32'hffff_fffe);
    apb(1'b0, ASRC_CTRL_OFS, 32'h0000_0000);
    check({err, rd}, 33'h0_0000_0000, "control cleared");
    apb(1'b0, 8'h08, 32'h0000_0000);
    check({err, rd}, 33'h1_0000_0000, "unmapped read");
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    check(err, 1'b1, "unmapped write");
    $display("test registers done");
    sb <= 1'b0;
    repeat (4) @(posedge pclk);
    check({outs[7:2], outs[0]}, 7'h00, "standby lost");
    status({d5, aux_n, 3'b000}, "reset on standby loss");
    sb <= 1'b1;
    repeat (POR + MW + 60) @(posedge pclk);
    check(outs, 8'h90, "active at 2.5 V after new trip");
    $display("test new trip done");
    stop_test();
  end
endmodule : asrc_core_tb
`default_nettype wire
